// ---- src/csr_pkg.sv ----
// Purpose: shared constants and types for the clock select and reset control block
// Assumes: 100 MHz I_MCLK, APB register access with 32-bit data
// Notes: times are kept in their own unit, cycle counts are derived from them

package csr_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TIME_RESUME_SHORT_US = 128;
	localparam int TIME_RESUME_LONG_MS = 4;
	localparam int TIME_INT_WAKE_US = 8;
	localparam int TIME_START_US = 1000;
	localparam int TIME_WDOG_HOLD_MS = 2;
	localparam int CYC_RESUME_SHORT = (TIME_RESUME_SHORT_US * 1000) / CLK_PERIOD_NS;
	localparam int CYC_RESUME_LONG = (TIME_RESUME_LONG_MS * 1000000) / CLK_PERIOD_NS;
	localparam int CYC_INT_WAKE = (TIME_INT_WAKE_US * 1000) / CLK_PERIOD_NS;
	localparam int CYC_START = (TIME_START_US * 1000) / CLK_PERIOD_NS;
	localparam int CYC_WDOG_HOLD = (TIME_WDOG_HOLD_MS * 1000000) / CLK_PERIOD_NS;
	localparam int TIMER_W = 20;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CLOCK_CONFIGURATION = 8'h00;
	localparam logic [7:0] ADDR_PROC_STATUS = 8'h04;
	localparam logic [7:0] ADDR_AUX_PORT = 8'h08;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int STAT_EXT_MODE_BIT = 0;
	localparam int STAT_HALT_BIT = 1;
	localparam int STAT_UNDERVOLT_BIT = 4;
	localparam int STAT_WDOG_BIT = 6;
	localparam int AUX_PIN_BIT = 1;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [7:0] STACK_RESET = 8'h00;

	// clock configuration fields, msb first
	typedef struct packed {
		logic resume_long;
		logic [2:0] wake_adj;
		logic undervolt_dis;
		logic precision_en;
		logic clk_out_dis;
		logic ext_osc_en;
	} csr_cfg_type;

	// reset cause flags
	typedef struct packed {
		logic wdog;
		logic undervolt;
	} csr_cause_type;

	typedef enum logic [2:0] {
		ST_STARTUP,
		ST_RUN,
		ST_SWITCH_STABLE,
		ST_RELEASE_DELAY,
		ST_WDOG_HOLD,
		ST_SUSPEND,
		ST_WAKE_STABLE
	} csr_state_type;

endpackage : csr_pkg

// ---- src/csr_delay_timer.sv ----
// Purpose: loadable down counter that measures one release delay
// Assumes: i_start is a one-cycle pulse, i_load at least 1
// Notes: o_done pulses one cycle when the loaded count has run out

module csr_delay_timer #(
	parameter int W = 20
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_start,
	input wire logic [W-1:0] i_load,
	output logic o_done
);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_done;

	// --------------------------------------------------------
	// next count
	// --------------------------------------------------------
	// a start reloads even when a delay is running
	always_comb begin
		next_count = count;
		next_done = 1'b0;
		if (i_start) begin
			next_count = i_load;
		end else if (count != '0) begin
			next_count = count - 1'b1;
			next_done = (count == {{(W-1){1'b0}}, 1'b1});
		end
	end

	// registers only
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count <= '0;
			o_done <= 1'b0;
		end else begin
			count <= next_count;
			o_done <= next_done;
		end
	end

endmodule : csr_delay_timer

// ---- src/csr_clock_reset_ctrl.sv ----
// Purpose: clock source selection, release delays and reset sequencing
// Assumes: comparators, stable flag and pins are asynchronous; core events share I_MCLK
// Notes: the delay timer runs on I_MCLK, which follows whichever oscillator is selected
//
// Our own choices: the APB interface to the registers and the address map.

module csr_clock_reset_ctrl
	import csr_pkg::*;
#(
	parameter int START_CYCLES = CYC_START,
	parameter int RESUME_SHORT_CYCLES = CYC_RESUME_SHORT,
	parameter int RESUME_LONG_CYCLES = CYC_RESUME_LONG,
	parameter int WDOG_HOLD_CYCLES = CYC_WDOG_HOLD
) (
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic I_UNDERVOLT,
	input wire logic I_DROPOUT,
	input wire logic I_EXT_CLK_STABLE,
	input wire logic I_OSC_INPUT_PIN,
	input wire logic I_INT_CLK,
	input wire logic I_WDOG_TIMEOUT,
	input wire logic I_SUSPEND_ENTER,
	input wire logic I_WAKE,
	input wire logic I_USB_TRAFFIC,
	input wire logic I_WAKE_IRQ_EN,
	output logic O_OSC_OUTPUT_PIN,
	output logic O_OSC_OUTPUT_OE,
	output logic O_OSC_INPUT_PULLDOWN,
	output logic O_INT_OSC_EN,
	output logic O_EXT_OSC_EN,
	output logic O_CLK_SEL_EXT,
	output logic O_PRECISION_TUNE,
	output logic O_UNDERVOLT_DET_EN,
	output logic [2:0] O_WAKE_ADJ,
	output logic O_WAKE_TIMER_EN,
	output logic O_CPU_HALT,
	output logic O_CORE_RESET,
	output logic [15:0] O_RESET_VECTOR,
	output logic [7:0] O_PROG_STACK_PTR_INIT,
	output logic [7:0] O_DATA_STACK_PTR_INIT,
	output logic O_PUSH_INHIBIT,
	output logic O_PIN_HIZ
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic undervolt_s, dropout_s, ext_stable_s, osc_in_s, int_clk_s;

	assign async_in = {I_UNDERVOLT, I_DROPOUT, I_EXT_CLK_STABLE, I_OSC_INPUT_PIN, I_INT_CLK};
	assign {undervolt_s, dropout_s, ext_stable_s, osc_in_s, int_clk_s} = sync_b;

	// two flops per asynchronous input
	generate
		for (genvar g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
				if (!I_RESET_N) begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
				end else begin
					sync_a[g] <= async_in[g];
					sync_b[g] <= sync_a[g];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == ADDR_CLOCK_CONFIGURATION) || (a == ADDR_PROC_STATUS) || (a == ADDR_AUX_PORT);
	endfunction : addr_mapped

	logic apb_fire, wr_cfg, wr_stat;
	assign apb_fire = i_psel && i_penable && o_pready;
	assign wr_cfg = apb_fire && i_pwrite && (i_paddr == ADDR_CLOCK_CONFIGURATION);
	assign wr_stat = apb_fire && i_pwrite && (i_paddr == ADDR_PROC_STATUS);

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	csr_state_type state, next_state;
	csr_cfg_type cfg, next_cfg;
	csr_cause_type cause, next_cause;
	logic ext_mode, next_ext_mode;
	logic traffic_seen, next_traffic_seen;
	logic in_reset, next_in_reset;
	logic tmr_start;
	logic tmr_start_any;
	logic [TIMER_W-1:0] tmr_load;
	logic tmr_done;
	logic uv_event, wd_event;
	logic [TIMER_W-1:0] resume_load;

	// undervoltage reset only while enabled and awake, dropout always
	assign uv_event = dropout_s || (undervolt_s && !cfg.undervolt_dis && state != ST_SUSPEND);
	assign wd_event = I_WDOG_TIMEOUT;
	assign resume_load = cfg.resume_long ? TIMER_W'(RESUME_LONG_CYCLES)
		: TIMER_W'(RESUME_SHORT_CYCLES);

	csr_delay_timer #(
		.W(TIMER_W)
	) u_delay (
		.i_clk(I_MCLK),
		.i_reset_n(I_RESET_N),
		.i_start(tmr_start_any),
		.i_load(tmr_load),
		.o_done(tmr_done)
	);

	// sequencing, clock mode, configuration and cause flags
	always_comb begin
		next_state = state;
		next_cfg = cfg;
		next_cause = cause;
		next_ext_mode = ext_mode;
		next_traffic_seen = traffic_seen;
		next_in_reset = in_reset;
		tmr_start = 1'b0;
		tmr_load = TIMER_W'(START_CYCLES);
		// write one clears a cause; a new event below still wins
		if (wr_stat) begin
			if (i_pwdata[STAT_UNDERVOLT_BIT]) begin
				next_cause.undervolt = 1'b0;
			end
			if (i_pwdata[STAT_WDOG_BIT]) begin
				next_cause.wdog = 1'b0;
			end
		end
		if (wr_cfg) begin
			next_cfg = csr_cfg_type'(i_pwdata[7:0]);
		end
		case (state)
			ST_STARTUP: begin
				if (tmr_done) begin
					next_state = ST_RUN;
					next_in_reset = 1'b0;
				end
			end
			ST_RUN: begin
				if (wr_cfg && i_pwdata[0] && !ext_mode) begin
					next_ext_mode = 1'b1;
					next_state = ST_SWITCH_STABLE;
				end else if (I_SUSPEND_ENTER) begin
					next_state = ST_SUSPEND;
				end
			end
			ST_SWITCH_STABLE, ST_WAKE_STABLE: begin
				if (ext_stable_s) begin
					tmr_start = 1'b1;
					tmr_load = resume_load;
					next_state = ST_RELEASE_DELAY;
				end
			end
			ST_RELEASE_DELAY, ST_WDOG_HOLD: begin
				if (tmr_done) begin
					next_state = ST_RUN;
					next_in_reset = 1'b0;
				end
			end
			ST_SUSPEND: begin
				if (I_WAKE) begin
					next_ext_mode = cfg.ext_osc_en;
					if (cfg.ext_osc_en) begin
						next_state = ST_WAKE_STABLE;
					end else begin
						tmr_start = 1'b1;
						tmr_load = TIMER_W'(CYC_INT_WAKE);
						next_state = ST_RELEASE_DELAY;
					end
				end
			end
			default: begin
				next_state = ST_STARTUP;
			end
		endcase
		// precision tuning arms on traffic, drops with the bit
		if (!cfg.precision_en) begin
			next_traffic_seen = 1'b0;
		end else if (I_USB_TRAFFIC) begin
			next_traffic_seen = 1'b1;
		end
		// resets override everything, except that a watchdog keeps ext_mode; cause register is kept
		if (uv_event) begin
			next_cfg = csr_cfg_type'(CFG_RESET);
			next_ext_mode = 1'b0;
			next_cause.undervolt = 1'b1;
			next_traffic_seen = 1'b0;
			next_in_reset = 1'b1;
			tmr_start = 1'b1;
			tmr_load = TIMER_W'(START_CYCLES);
			next_state = ST_STARTUP;
		end else if (wd_event) begin
			next_cfg = csr_cfg_type'(CFG_RESET);
			next_cause.wdog = 1'b1;
			next_traffic_seen = 1'b0;
			next_in_reset = 1'b1;
			tmr_start = 1'b1;
			tmr_load = TIMER_W'(WDOG_HOLD_CYCLES);
			next_state = ST_WDOG_HOLD;
		end
	end

	// registers only; power-up is a startup wait on the internal clock
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state <= ST_STARTUP;
			cfg <= csr_cfg_type'(CFG_RESET);
			cause <= '0;
			ext_mode <= 1'b0;
			traffic_seen <= 1'b0;
			in_reset <= 1'b1;
		end else begin
			state <= next_state;
			cfg <= next_cfg;
			cause <= next_cause;
			ext_mode <= next_ext_mode;
			traffic_seen <= next_traffic_seen;
			in_reset <= next_in_reset;
		end
	end

	// power-up startup wait starts once after release
	logic por_kick, next_por_kick;
	always_comb begin
		next_por_kick = 1'b0;
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			por_kick <= 1'b1;
		end else begin
			por_kick <= next_por_kick;
		end
	end
	assign tmr_start_any = tmr_start || por_kick;

	// ------------------------------------------------------------
	// apb slave, one wait state
	// ------------------------------------------------------------
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [31:0] rd_word;

	// read mux
	always_comb begin
		rd_word = '0;
		case (i_paddr)
			ADDR_CLOCK_CONFIGURATION: begin
				rd_word[7:0] = cfg;
			end
			ADDR_PROC_STATUS: begin
				rd_word[STAT_EXT_MODE_BIT] = ext_mode;
				rd_word[STAT_HALT_BIT] = (state != ST_RUN);
				rd_word[STAT_UNDERVOLT_BIT] = cause.undervolt;
				rd_word[STAT_WDOG_BIT] = cause.wdog;
			end
			ADDR_AUX_PORT: begin
				rd_word[AUX_PIN_BIT] = !ext_mode && osc_in_s;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// pready rises in the second access cycle
	always_comb begin
		next_pready = i_psel && i_penable && !o_pready;
		next_prdata = o_prdata;
		next_pslverr = 1'b0;
		if (next_pready) begin
			next_prdata = i_pwrite ? 32'h0000_0000 : rd_word;
			next_pslverr = !addr_mapped(i_paddr);
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			o_pready <= 1'b0;
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= next_pready;
			o_prdata <= next_prdata;
			o_pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	logic suspended;
	assign suspended = (state == ST_SUSPEND);

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_OSC_OUTPUT_PIN <= 1'b0;
			O_OSC_OUTPUT_OE <= 1'b1;
			O_OSC_INPUT_PULLDOWN <= 1'b1;
			O_INT_OSC_EN <= 1'b1;
			O_EXT_OSC_EN <= 1'b0;
			O_CLK_SEL_EXT <= 1'b0;
			O_PRECISION_TUNE <= 1'b0;
			O_UNDERVOLT_DET_EN <= 1'b1;
			O_WAKE_ADJ <= 3'h0;
			O_WAKE_TIMER_EN <= 1'b0;
			O_CPU_HALT <= 1'b1;
			O_CORE_RESET <= 1'b1;
			O_RESET_VECTOR <= RESET_VECTOR;
			O_PROG_STACK_PTR_INIT <= STACK_RESET;
			O_DATA_STACK_PTR_INIT <= STACK_RESET;
			O_PUSH_INHIBIT <= 1'b1;
			O_PIN_HIZ <= 1'b1;
		end else begin
			O_OSC_OUTPUT_PIN <= cfg.clk_out_dis ? 1'b1 : int_clk_s;
			O_OSC_OUTPUT_OE <= !ext_mode;
			O_OSC_INPUT_PULLDOWN <= !ext_mode;
			O_INT_OSC_EN <= !ext_mode && !suspended;
			O_EXT_OSC_EN <= ext_mode && !suspended;
			O_CLK_SEL_EXT <= ext_mode;
			O_PRECISION_TUNE <= !ext_mode && traffic_seen;
			O_UNDERVOLT_DET_EN <= !cfg.undervolt_dis && !suspended;
			O_WAKE_ADJ <= cfg.wake_adj;
			O_WAKE_TIMER_EN <= I_WAKE_IRQ_EN;
			O_CPU_HALT <= (next_state != ST_RUN);
			O_CORE_RESET <= next_in_reset;
			O_RESET_VECTOR <= RESET_VECTOR;
			O_PROG_STACK_PTR_INIT <= STACK_RESET;
			O_DATA_STACK_PTR_INIT <= STACK_RESET;
			O_PUSH_INHIBIT <= next_in_reset;
			O_PIN_HIZ <= next_in_reset;
		end
	end

endmodule : csr_clock_reset_ctrl

// ---- bench/csr_clock_reset_ctrl_props.sv ----
// Purpose: port checks for the clock select and reset control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: a shadow of the last accepted configuration write feeds the field checks
module csr_ctrl_props
	import csr_pkg::*;
#(
	parameter int RESUME_SHORT_CYCLES = 20
) (
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic I_EXT_CLK_STABLE,
	input wire logic I_WDOG_TIMEOUT,
	input wire logic O_OSC_OUTPUT_PIN,
	input wire logic O_OSC_INPUT_PULLDOWN,
	input wire logic O_INT_OSC_EN,
	input wire logic O_CLK_SEL_EXT,
	input wire logic O_UNDERVOLT_DET_EN,
	input wire logic [2:0] O_WAKE_ADJ,
	input wire logic O_CPU_HALT,
	input wire logic [15:0] O_RESET_VECTOR,
	input wire logic [7:0] O_PROG_STACK_PTR_INIT,
	input wire logic [7:0] O_DATA_STACK_PTR_INIT
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// helper state
	// ------------------------------------------------------------
	logic wr_cfg;
	logic [7:0] shadow;
	logic [7:0] next_shadow;
	int stable_cnt;
	int next_stable_cnt;
	// accepted write to the configuration word
	assign wr_cfg = i_psel && i_penable && o_pready && i_pwrite && i_paddr == ADDR_CLOCK_CONFIGURATION;
	// shadow of the written value and length of the current stable stretch
	always_comb begin
		next_shadow = wr_cfg ? i_pwdata[7:0] : shadow;
		next_stable_cnt = I_EXT_CLK_STABLE ? stable_cnt + 1 : 0;
	end
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			shadow <= 8'h00;
			stable_cnt <= 0;
		end else begin
			shadow <= next_shadow;
			stable_cnt <= next_stable_cnt;
		end
	end
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RESET_N);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_vec;
		O_RESET_VECTOR == 16'h0000 && O_PROG_STACK_PTR_INIT == 8'h00 && O_DATA_STACK_PTR_INIT == 8'h00;
	endproperty
	a_vec: assert property (p_vec) else $error("restart vector or stack init not zero");
	property p_adj;
		wr_cfg |-> ##2 O_WAKE_ADJ == shadow[6:4];
	endproperty
	a_adj: assert property (p_adj) else $error("wake adjust does not follow write");
	property p_uv;
		wr_cfg |-> ##2 O_UNDERVOLT_DET_EN == !shadow[3];
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage enable does not follow write");
	property p_pin;
		wr_cfg && i_pwdata[1] && !i_pwdata[0] && !O_CLK_SEL_EXT |-> ##2 O_OSC_OUTPUT_PIN [*3];
	endproperty
	a_pin: assert property (p_pin) else $error("output pin not held high");
	property p_switch;
		wr_cfg && i_pwdata[0] && !O_CLK_SEL_EXT && !O_CPU_HALT |-> ##[1:2] (O_CPU_HALT && O_CLK_SEL_EXT && !O_INT_OSC_EN);
	endproperty
	a_switch: assert property (p_switch) else $error("switch did not halt and stop internal");
	property p_keep;
		wr_cfg && !i_pwdata[0] && O_CLK_SEL_EXT |-> ##1 O_CLK_SEL_EXT [*4];
	endproperty
	a_keep: assert property (p_keep) else $error("clearing enable left external mode");
	property p_release;
		$fell(O_CPU_HALT) && O_CLK_SEL_EXT |-> stable_cnt >= RESUME_SHORT_CYCLES;
	endproperty
	a_release: assert property (p_release) else $error("released before delay ran out");
	property p_pd;
		!O_CLK_SEL_EXT && $stable(O_CLK_SEL_EXT) |-> O_OSC_INPUT_PULLDOWN;
	endproperty
	a_pd: assert property (p_pd) else $error("no pull-down in internal mode");
	property p_wdog;
		I_WDOG_TIMEOUT && !O_CPU_HALT |-> ##2 ($stable(O_CLK_SEL_EXT) && O_CPU_HALT) [*3];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog changed clock mode");
endmodule : csr_ctrl_props

bind csr_clock_reset_ctrl csr_ctrl_props #(.RESUME_SHORT_CYCLES(RESUME_SHORT_CYCLES)) csr_ctrl_props_i (
	.I_MCLK, .I_RESET_N, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .I_EXT_CLK_STABLE,
	.I_WDOG_TIMEOUT, .O_OSC_OUTPUT_PIN, .O_OSC_INPUT_PULLDOWN, .O_INT_OSC_EN, .O_CLK_SEL_EXT,
	.O_UNDERVOLT_DET_EN, .O_WAKE_ADJ, .O_CPU_HALT, .O_RESET_VECTOR, .O_PROG_STACK_PTR_INIT,
	.O_DATA_STACK_PTR_INIT);

// ---- bench/csr_ext_osc_model.sv ----
// Purpose: external resonator model reporting when its oscillation is stable
// Assumes: enable comes from the block, start-up counted in core clocks
// Notes: slow start mimics a crystal, fast start a ceramic resonator
module csr_ext_osc_model #(
	parameter int START_FAST = 8,
	parameter int START_SLOW = 60
) (
	input wire logic i_clk,
	input wire logic i_en,
	input wire logic i_slow,
	output logic o_stable
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// start-up count restarts whenever the oscillator is switched off
	always @(posedge i_clk) begin
		if (!i_en) cnt <= 0;
		else if (cnt < START_SLOW) cnt <= cnt + 1;
	end
	assign o_stable = i_en && cnt >= (i_slow ? START_SLOW : START_FAST);
endmodule : csr_ext_osc_model

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for the clock select and reset control block
// Assumes: short cycle counts set through parameters
// Notes: reads note expected data in a queue that the monitor drains
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import csr_pkg::*;
	localparam int SHORT = 20, LONG = 40, FAST = 8, SLOW = 60;
	localparam logic [5:0] EV_UV = 6'h01, EV_DROP = 6'h02, EV_WDOG = 6'h04, EV_SUSP = 6'h08, EV_WAKE = 6'h10;
	localparam logic [5:0] EV_USB = 6'h20;
	logic I_MCLK = 1'h0, I_RESET_N = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, slow = 1'h0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata;
	logic [5:0] ev = 6'h00;
	logic o_pready, o_pslverr, I_EXT_CLK_STABLE, I_OSC_INPUT_PIN = 1'h0, I_INT_CLK = 1'h0, I_WAKE_IRQ_EN = 1'h0;
	logic I_UNDERVOLT, I_DROPOUT, I_WDOG_TIMEOUT, I_SUSPEND_ENTER, I_WAKE, I_USB_TRAFFIC;
	logic O_OSC_OUTPUT_PIN, O_OSC_OUTPUT_OE, O_OSC_INPUT_PULLDOWN, O_INT_OSC_EN, O_EXT_OSC_EN, O_CLK_SEL_EXT;
	logic O_PRECISION_TUNE, O_UNDERVOLT_DET_EN, O_WAKE_TIMER_EN, O_CPU_HALT, O_CORE_RESET, O_PUSH_INHIBIT, O_PIN_HIZ;
	logic [2:0] O_WAKE_ADJ;
	logic [15:0] O_RESET_VECTOR;
	logic [7:0] O_PROG_STACK_PTR_INIT, O_DATA_STACK_PTR_INIT, cfg;
	logic [32:0] exp_q[$];
	int failures = 0, checked = 0, seed = 32'h5b543f51, n;
	// ------------------------------------------------------------
	// clock, events and instances
	// ------------------------------------------------------------
	always #5 I_MCLK = ~I_MCLK;
	always @(posedge I_MCLK) I_INT_CLK <= ~I_INT_CLK;
	assign {I_USB_TRAFFIC, I_WAKE, I_SUSPEND_ENTER, I_WDOG_TIMEOUT, I_DROPOUT, I_UNDERVOLT} = ev;
	csr_clock_reset_ctrl #(.START_CYCLES(30), .RESUME_SHORT_CYCLES(SHORT), .RESUME_LONG_CYCLES(LONG),
		.WDOG_HOLD_CYCLES(25)) csr_clock_reset_ctrl_i (.I_MCLK, .I_RESET_N, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .I_UNDERVOLT, .I_DROPOUT, .I_EXT_CLK_STABLE,
		.I_OSC_INPUT_PIN, .I_INT_CLK, .I_WDOG_TIMEOUT, .I_SUSPEND_ENTER, .I_WAKE, .I_USB_TRAFFIC, .I_WAKE_IRQ_EN,
		.O_OSC_OUTPUT_PIN, .O_OSC_OUTPUT_OE, .O_OSC_INPUT_PULLDOWN, .O_INT_OSC_EN, .O_EXT_OSC_EN, .O_CLK_SEL_EXT,
		.O_PRECISION_TUNE, .O_UNDERVOLT_DET_EN, .O_WAKE_ADJ, .O_WAKE_TIMER_EN, .O_CPU_HALT, .O_CORE_RESET,
		.O_RESET_VECTOR, .O_PROG_STACK_PTR_INIT, .O_DATA_STACK_PTR_INIT, .O_PUSH_INHIBIT, .O_PIN_HIZ);
	csr_ext_osc_model #(.START_FAST(FAST), .START_SLOW(SLOW)) csr_ext_osc_model_i (.i_clk(I_MCLK),
		.i_en(O_EXT_OSC_EN), .i_slow(slow), .o_stable(I_EXT_CLK_STABLE));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge I_MCLK);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge I_MCLK);
		i_penable <= 1'h1;
		k = 0;
		do begin
			@(negedge I_MCLK);
			k++;
		end while (o_pready !== 1'h1 && k < 20);
		if (k >= 20) begin
			failures++;
			report_and_stop();
		end
		@(posedge I_MCLK);
		i_psel <= 1'h0;
		i_penable <= 1'h0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'h0, a, 32'h0);
	endtask : rd
	task automatic pulse(input logic [5:0] m, input int len);
		@(posedge I_MCLK);
		ev <= m;
		repeat (len) @(posedge I_MCLK);
		ev <= 6'h00;
	endtask : pulse
	// counts halted cycles until the core runs again
	task automatic wait_run(output int c);
		c = 0;
		while (O_CPU_HALT !== 1'h0 && c < 3000) begin
			@(negedge I_MCLK);
			c++;
		end
		if (c >= 3000) begin
			failures++;
			report_and_stop();
		end
	endtask : wait_run
	// read monitor: oldest note against pslverr and read data
	always @(posedge I_MCLK) begin
		if (i_psel && i_penable && o_pready === 1'h1 && !i_pwrite) check({o_pslverr, o_prdata}, exp_q.pop_front());
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge I_MCLK);
		I_RESET_N <= 1'h1;
		@(negedge I_MCLK);
		check(O_INT_OSC_EN && !O_CLK_SEL_EXT && O_OSC_OUTPUT_OE, 1'h1);
		check({O_RESET_VECTOR, O_PROG_STACK_PTR_INIT, O_DATA_STACK_PTR_INIT}, 33'h0);
		check({O_CPU_HALT, O_CORE_RESET, O_PIN_HIZ, O_PUSH_INHIBIT}, 33'hf);
		rd(ADDR_CLOCK_CONFIGURATION, {25'h0, CFG_RESET});
		// power-up wait ends by itself on the internal clock
		wait_run(n);
		check({O_CORE_RESET, O_PIN_HIZ, O_PUSH_INHIBIT, O_CLK_SEL_EXT}, 33'h0);
		$display("test power-up done");
		// both supply causes restart in internal mode and set the cause flag; no return is issued
		for (int k = 0; k < 2; k++) begin
			pulse(k ? EV_DROP : EV_UV, 4);
			repeat (4) @(negedge I_MCLK);
			check(O_CPU_HALT, 1'h1);
			wait_run(n);
			check(O_INT_OSC_EN && !O_CLK_SEL_EXT, 1'h1);
			check({O_CORE_RESET, O_PUSH_INHIBIT, O_PIN_HIZ}, 33'h0);
			rd(ADDR_PROC_STATUS, 33'h10);
			apb(1'h1, ADDR_PROC_STATUS, 32'h10);
			rd(ADDR_PROC_STATUS, 33'h0);
		end
		$display("test supply done");
		// random configuration fields and the pins they steer
		for (int k = 0; k < 4; k++) begin
			cfg = 8'($random(seed)) & 8'h7e;
			@(posedge I_MCLK);
			I_OSC_INPUT_PIN <= cfg[3];
			I_WAKE_IRQ_EN <= cfg[5];
			apb(1'h1, ADDR_CLOCK_CONFIGURATION, {24'h0, cfg});
			pulse(EV_USB, 1);
			repeat (3) @(negedge I_MCLK);
			check(O_WAKE_ADJ, cfg[6:4]);
			check(O_WAKE_TIMER_EN, cfg[5]);
			check(O_UNDERVOLT_DET_EN, !cfg[3]);
			check(O_PRECISION_TUNE, cfg[2]);
			check(O_OSC_OUTPUT_PIN, cfg[1] | !I_INT_CLK);
			rd(ADDR_CLOCK_CONFIGURATION, {25'h0, cfg});
			rd(ADDR_AUX_PORT, {31'h0, cfg[3], 1'h0});
		end
		rd(8'h0c, 33'h100000000);
		$display("test config done");
		// switch with each delay, then watchdog or clear, then suspend and wake
		for (int k = 0; k < 2; k++) begin
			slow <= k[0];
			apb(1'h1, ADDR_CLOCK_CONFIGURATION, k ? 32'h81 : 32'h01);
			repeat (2) @(negedge I_MCLK);
			check({O_CPU_HALT, O_CLK_SEL_EXT, O_EXT_OSC_EN, O_INT_OSC_EN, O_OSC_OUTPUT_OE}, 33'h1c);
			wait_run(n);
			check(k ? n >= SLOW + LONG : (n >= FAST + SHORT && n < FAST + LONG), 1'h1);
			if (k) begin
				pulse(EV_WDOG, 1);
				repeat (3) @(negedge I_MCLK);
				check({O_CPU_HALT, O_CORE_RESET}, 33'h3);
				wait_run(n);
			end else apb(1'h1, ADDR_CLOCK_CONFIGURATION, 32'h0);
			repeat (5) @(negedge I_MCLK);
			check(O_CLK_SEL_EXT, 1'h1);
			rd(ADDR_PROC_STATUS, k ? 33'h41 : 33'h1);
			rd(ADDR_CLOCK_CONFIGURATION, 33'h0);
			pulse(EV_SUSP, 1);
			repeat (5) @(negedge I_MCLK);
			pulse(EV_WAKE, 1);
			repeat (2) @(negedge I_MCLK);
			wait_run(n);
			check({O_CLK_SEL_EXT, O_INT_OSC_EN}, 33'h1);
			$display("test switch %0d done", k);
		end
		// wake from suspend with the external oscillator selected
		apb(1'h1, ADDR_CLOCK_CONFIGURATION, 32'h01);
		@(negedge I_MCLK);
		wait_run(n);
		pulse(EV_SUSP, 1);
		repeat (5) @(negedge I_MCLK);
		pulse(EV_WAKE, 1);
		repeat (2) @(negedge I_MCLK);
		wait_run(n);
		check(n >= SLOW + SHORT && n < SLOW + LONG, 1'h1);
		check({O_CLK_SEL_EXT, O_EXT_OSC_EN, O_INT_OSC_EN}, 33'h6);
		$display("test wake external done");
		report_and_stop();
	end
endmodule : tb_top
